// [rtl/lmc_link_manager_regs.v]
// lmc_link_manager_regs.v: apb register bank for the central link manager:
// global enable, feature capability bits, refresh timers via index/data,
// idle lane state defaults and staged memory-controller settings.
// assumes a 40 MHz pclk; power_ok_n is an asynchronous pin, synchronised.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "lmc_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - global enable bit applies only after warm reset; a status, data, active or unmapped write in the release cycle blocks it
// - no feature runs without its capability bit
// - mode send bit, cleared reset and power
// - disconnect bit, cleared reset and power
// - width send bit, cleared by power only
// - freq send bit, cleared by power only
// - idle refresh bit, cleared by power only
// - refresh bit, cleared reset and power
// - stop interval field bits 11:6
// - stop length field bits 5:0
// - index 0 caps view, index 2 timers
// - data port fields follow current index
// - staged values apply on push plus qualifier
// - push bit 20, qualifier bit 21
// - receiver idle lane state bits 24:23
module lmc_link_manager_regs
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        power_ok_n,
  input  wire        warm_reset_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         manager_active,
  output reg         mode_send_enable,
  output reg         disconnect_enable,
  output reg         width_send_enable,
  output reg         freq_send_enable,
  output reg         idle_refresh_enable,
  output reg         refresh_enable,
  output reg  [5:0]  refresh_stop_interval,
  output reg  [5:0]  refresh_stop_length,
  output reg  [1:0]  rx_idle_lane_state,
  output reg  [1:0]  tx_idle_lane_state,
  output reg  [31:0] mc_active0,
  output reg  [31:0] mc_active1
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers for power-good and warm reset
  reg  [1:0]  pok_sync_q;
  reg  [1:0]  wrst_sync_q;
  reg         wrst_prev_q;
  wire        pok_lost;
  wire        warm_rise;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pok_sync_q  <= `LMC_RST_POK;                    // power assumed good
      wrst_sync_q <= 2'h0;
      wrst_prev_q <= 1'b0;
    end
    else
    begin
      pok_sync_q  <= {pok_sync_q[0], power_ok_n};
      wrst_sync_q <= {wrst_sync_q[0], warm_reset_n};
      wrst_prev_q <= wrst_sync_q[1];
    end
  end

  // sync resets high so presetn alone never looks like a power event
  assign pok_lost  = ~pok_sync_q[1];                  // power-good event
  assign warm_rise = wrst_sync_q[1] & ~wrst_prev_q;   // warm reset released

  ////////////////////////////////////////////////////////////////////////////
  // apb decode: single wait-free access phase
  wire        wr_en;
  wire        rd_en;
  wire        hit_known;
  wire [3:0]  idx;
  reg  [31:0] global_q;
  reg  [3:0]  idx_q;
  reg  [2:0]  cap_hard_q;
  reg  [2:0]  cap_soft_q;
  wire [5:0]  cap_q;
  reg  [5:0]  interval_q;
  reg  [5:0]  length_q;
  reg  [1:0]  rx_ls_q;
  reg  [1:0]  tx_ls_q;
  reg  [31:0] train_q;
  reg         push_q;
  reg         qual_q;
  reg  [31:0] update_q;
  reg  [31:0] stage0_q;
  reg  [31:0] stage1_q;
  reg         en_live_q;
  reg  [31:0] rdata_d;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign idx   = idx_q;
  // hard caps (bits 16,17,21) clear on reset, soft caps (18..20) do not
  assign cap_q = {cap_hard_q[2], cap_soft_q, cap_hard_q[1:0]};
  assign hit_known = (paddr == `LMC_OFF_MC_UPDATE)  |
                     (paddr == `LMC_OFF_MC_STAGE0)  |
                     (paddr == `LMC_OFF_MC_STAGE1)  |
                     (paddr == `LMC_OFF_MC_ACTIVE0) |
                     (paddr == `LMC_OFF_MC_ACTIVE1) |
                     (paddr == `LMC_OFF_GLOBAL)     |
                     (paddr == `LMC_OFF_STATUS)     |
                     (paddr == `LMC_OFF_TRAIN0)     |
                     (paddr == `LMC_OFF_INDEX)      |
                     (paddr == `LMC_OFF_DATA);

  ////////////////////////////////////////////////////////////////////////////
  // capability bits cleared by reset and power-good
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap_hard_q[0] <= 1'b0;
      cap_hard_q[1] <= 1'b0;
      cap_hard_q[2] <= 1'b0;
      interval_q    <= `LMC_RST_TIMER;
      length_q      <= `LMC_RST_TIMER;
    end
    else if (pok_lost)
    begin
      cap_hard_q    <= `LMC_RST_CAP3;
      interval_q    <= `LMC_RST_TIMER;
      length_q      <= `LMC_RST_TIMER;
    end
    else if (wr_en && paddr == `LMC_OFF_DATA)
    begin
      if (idx == `LMC_IDX_CAPS)
      begin
        cap_hard_q[0] <= pwdata[`LMC_BIT_MODE_SEND];
        cap_hard_q[1] <= pwdata[`LMC_BIT_DISCONNECT];
        cap_hard_q[2] <= pwdata[`LMC_BIT_REFRESH];
      end
      else if (idx == `LMC_IDX_TIMERS)
      begin
        interval_q <= pwdata[`LMC_INT_HI:`LMC_INT_LO];
        length_q   <= pwdata[`LMC_LEN_HI:`LMC_LEN_LO];
      end
    end
  end

  // capability bits that survive ordinary reset: no async reset term,
  // cleared only while power-good is lost; unknown until the first
  // power-good event, so bring-up must pulse power_ok_n low
  always @(posedge pclk)
  begin
    if (pok_lost)
    begin
      cap_soft_q[0] <= 1'b0;
      cap_soft_q[1] <= 1'b0;
      cap_soft_q[2] <= 1'b0;
    end
    else if (wr_en && paddr == `LMC_OFF_DATA && idx == `LMC_IDX_CAPS)
    begin
      cap_soft_q[0] <= pwdata[`LMC_BIT_WIDTH_SEND];
      cap_soft_q[1] <= pwdata[`LMC_BIT_FREQ_SEND];
      cap_soft_q[2] <= pwdata[`LMC_BIT_IDLE_REFRESH];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ordinary registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      global_q  <= `LMC_RST_WORD;
      idx_q     <= `LMC_RST_IDX;
      rx_ls_q   <= `LMC_RST_LS;
      tx_ls_q   <= `LMC_RST_LS;
      train_q   <= `LMC_RST_WORD;
      push_q    <= 1'b0;
      qual_q    <= 1'b0;
      update_q  <= `LMC_RST_WORD;
      stage0_q  <= `LMC_RST_WORD;
      stage1_q  <= `LMC_RST_WORD;
      en_live_q <= 1'b0;
    end
    else
    begin
      // live enable captured only at warm reset release; a same-cycle write to status, data, active or unmapped offsets blocks it
      if (warm_rise)
        en_live_q <= global_q[`LMC_BIT_GLOBAL_EN];
      if (wr_en)
      begin
        case (paddr)
          `LMC_OFF_GLOBAL:
            global_q <= {31'h0, pwdata[`LMC_BIT_GLOBAL_EN]};
          `LMC_OFF_INDEX:
            idx_q <= pwdata[`LMC_IDX_HI:`LMC_IDX_LO];
          `LMC_OFF_TRAIN0:
          begin
            train_q <= pwdata;
            rx_ls_q <= pwdata[`LMC_RX_LS_HI:`LMC_RX_LS_LO];
            tx_ls_q <= pwdata[`LMC_TX_LS_HI:`LMC_TX_LS_LO];
          end
          `LMC_OFF_MC_UPDATE:
          begin
            update_q <= pwdata;
            push_q   <= pwdata[`LMC_BIT_PUSH];
            qual_q   <= pwdata[`LMC_BIT_QUAL];
          end
          `LMC_OFF_MC_STAGE0:
            stage0_q <= pwdata;
          `LMC_OFF_MC_STAGE1:
            stage1_q <= pwdata;
          default:
            en_live_q <= en_live_q;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped address reads zero with pslverr
  always @*
  begin
    rdata_d = 32'h00000000;
    case (paddr)
      `LMC_OFF_GLOBAL:
        rdata_d = global_q;
      `LMC_OFF_STATUS:
        rdata_d = {31'h0, en_live_q};
      `LMC_OFF_INDEX:
        rdata_d = {12'h000, idx_q, 16'h0000};
      // data port view follows the index written beforehand
      `LMC_OFF_DATA:
      begin
        if (idx_q == `LMC_IDX_CAPS)
          rdata_d = {10'h000, cap_q, 16'h0000};
        else if (idx_q == `LMC_IDX_TIMERS)
          rdata_d = {20'h00000, interval_q, length_q};
        else
          rdata_d = 32'h00000000;
      end
      `LMC_OFF_TRAIN0:
        rdata_d = {train_q[31:27], tx_ls_q, rx_ls_q, train_q[22:0]};
      `LMC_OFF_MC_UPDATE:
        rdata_d = {update_q[31:22], qual_q, push_q, update_q[19:0]};
      `LMC_OFF_MC_STAGE0:
        rdata_d = stage0_q;
      `LMC_OFF_MC_STAGE1:
        rdata_d = stage1_q;
      `LMC_OFF_MC_ACTIVE0:
        rdata_d = mc_active0;
      `LMC_OFF_MC_ACTIVE1:
        rdata_d = mc_active1;
      default:
        rdata_d = 32'h00000000;
    endcase
  end

  // registered apb answer, ready in the first access cycle
  // read data is taken from the setup cycle, writes land at access end
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_known;
      prdata  <= (psel & ~penable & ~pwrite) ? rdata_d : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // staged mc settings pushed only while both bits are set
  // clearing either bit freezes the settings in use
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mc_active0 <= `LMC_RST_WORD;
      mc_active1 <= `LMC_RST_WORD;
    end
    else if (push_q && qual_q)
    begin
      mc_active0 <= stage0_q;
      mc_active1 <= stage1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // feature outputs gated by live enable and own capability bit
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      manager_active        <= 1'b0;
      mode_send_enable      <= 1'b0;
      disconnect_enable     <= 1'b0;
      width_send_enable     <= 1'b0;
      freq_send_enable      <= 1'b0;
      idle_refresh_enable   <= 1'b0;
      refresh_enable        <= 1'b0;
      refresh_stop_interval <= `LMC_RST_TIMER;
      refresh_stop_length   <= `LMC_RST_TIMER;
      rx_idle_lane_state    <= `LMC_RST_LS;
      tx_idle_lane_state    <= `LMC_RST_LS;
    end
    else
    begin
      manager_active        <= en_live_q;
      mode_send_enable      <= en_live_q & cap_q[0];
      disconnect_enable     <= en_live_q & cap_q[1];
      width_send_enable     <= en_live_q & cap_q[2];
      freq_send_enable      <= en_live_q & cap_q[3];
      idle_refresh_enable   <= en_live_q & cap_q[4];
      refresh_enable        <= en_live_q & cap_q[5];
      refresh_stop_interval <= interval_q;
      refresh_stop_length   <= length_q;
      rx_idle_lane_state    <= rx_ls_q;
      tx_idle_lane_state    <= tx_ls_q;
    end
  end

endmodule

// [common/lmc_defs.vh]
// lmc_defs.vh: register offsets, field positions and reset values for the
// link manager control register bank.
// assumes inclusion by bare name from the design file; the bench files use literal values.
`ifndef LMC_DEFS_VH
`define LMC_DEFS_VH

// register byte offsets (apb word addresses)
`define LMC_OFF_MC_UPDATE      8'h2C
`define LMC_OFF_MC_STAGE0      8'h24
`define LMC_OFF_MC_STAGE1      8'h28
`define LMC_OFF_MC_ACTIVE0     8'h30
`define LMC_OFF_MC_ACTIVE1     8'h34
`define LMC_OFF_GLOBAL         8'h50
`define LMC_OFF_STATUS         8'h60
`define LMC_OFF_TRAIN0         8'hAC
`define LMC_OFF_INDEX          8'hF8
`define LMC_OFF_DATA           8'hFC

// field positions
`define LMC_BIT_GLOBAL_EN      0
`define LMC_BIT_WARM_RST       1
`define LMC_BIT_MODE_SEND      16
`define LMC_BIT_DISCONNECT     17
`define LMC_BIT_WIDTH_SEND     18
`define LMC_BIT_FREQ_SEND      19
`define LMC_BIT_IDLE_REFRESH   20
`define LMC_BIT_REFRESH        21
`define LMC_BIT_PUSH           20
`define LMC_BIT_QUAL           21
`define LMC_IDX_HI             19
`define LMC_IDX_LO             16
`define LMC_RX_LS_HI           24
`define LMC_RX_LS_LO           23
`define LMC_TX_LS_HI           26
`define LMC_TX_LS_LO           25
`define LMC_INT_HI             11
`define LMC_INT_LO             6
`define LMC_LEN_HI             5
`define LMC_LEN_LO             0

// index values
`define LMC_IDX_CAPS           4'h0
`define LMC_IDX_TIMERS         4'h2

// reset values
`define LMC_RST_WORD           32'h00000000
`define LMC_RST_CAP6           6'h00
`define LMC_RST_TIMER          6'h00
`define LMC_RST_LS             2'h0
`define LMC_RST_IDX            4'h0
`define LMC_RST_CAP3           3'h0
`define LMC_RST_POK            2'h3

`endif

// [tb/lmc_link_manager_regs_props.sv]
// lmc_link_manager_regs_props.sv: port assertions for the register bank.
// assumes one pclk domain, presetn asynchronous and active low.
`timescale 1ns/1ps
module lmc_props
(
  input wire        pclk,
  input wire        presetn,
  input wire        power_ok_n,
  input wire        warm_reset_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        manager_active,
  input wire        mode_send_enable,
  input wire        disconnect_enable,
  input wire        width_send_enable,
  input wire        freq_send_enable,
  input wire        idle_refresh_enable,
  input wire        refresh_enable,
  input wire [5:0]  refresh_stop_interval,
  input wire [5:0]  refresh_stop_length,
  input wire [1:0]  rx_idle_lane_state
);
  wire [5:0] feat;
  // the six feature outputs as one vector
  assign feat = {refresh_enable, idle_refresh_enable, freq_send_enable,
                 width_send_enable, disconnect_enable, mode_send_enable};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
////////////////////////////////////////////////////////////////////////////////
  // bus answer timing
  a_ready_zero_wait:
    assert property (psel && !penable |=> pready)
    else $error("no ready after a setup cycle");
  a_ready_one_cycle:
    assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_zero_data:
    assert property (pslverr |-> pready && prdata == 32'h00000000)
    else $error("error answer without ready or with data");
  a_rdata_idle_zero:
    assert property (!pready |-> prdata == 32'h00000000)
    else $error("read data outside an answer");
  // enable, capability and field behaviour
  a_feature_gated:
    assert property (feat != 6'h00 |-> manager_active ||
                     $past(manager_active))
    else $error("feature active while manager is off");
  a_enable_warm_only:
    assert property (warm_reset_n [*8] |=> $stable(manager_active))
    else $error("manager enable moved without warm reset");
  a_power_clears:
    assert property (!power_ok_n [*5] |-> feat == 6'h00 &&
      refresh_stop_interval == 6'h00 && refresh_stop_length == 6'h00)
    else $error("power event left features or timers set");
  a_lane_state_load:
    assert property (psel && penable && pready && pwrite && paddr == 8'hAC
      |=> rx_idle_lane_state == $past(pwdata[24:23]) or
      ##1 rx_idle_lane_state == $past(pwdata[24:23], 2))
    else $error("receiver lane state not loaded");
endmodule

bind lmc_link_manager_regs lmc_props u_lmc_props
(
  .pclk(pclk), .presetn(presetn), .power_ok_n(power_ok_n),
  .warm_reset_n(warm_reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .manager_active(manager_active),
  .mode_send_enable(mode_send_enable),
  .disconnect_enable(disconnect_enable),
  .width_send_enable(width_send_enable),
  .freq_send_enable(freq_send_enable),
  .idle_refresh_enable(idle_refresh_enable),
  .refresh_enable(refresh_enable),
  .refresh_stop_interval(refresh_stop_interval),
  .refresh_stop_length(refresh_stop_length),
  .rx_idle_lane_state(rx_idle_lane_state)
);

// [tb/lmc_link_manager_regs_tb.sv]
// lmc_link_manager_regs_tb.sv: self-checking bench with a register model.
// assumes the bench drives apb, warm reset and power-good pins itself.
`timescale 1ns/1ps
module lmc_link_manager_regs_tb;
  reg         pclk, presetn, power_ok_n, warm_reset_n, psel, penable, pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, seed, m_st0, m_st1, m_act0, m_act1, mask, exp;
  wire [31:0] prdata, mc_active0, mc_active1;
  wire        pready, pslverr, manager_active;
  wire [5:0]  feat, refresh_stop_interval, refresh_stop_length;
  wire [1:0]  rx_idle_lane_state, tx_idle_lane_state;
  reg  [5:0]  m_cap, m_int, m_len;
  reg  [3:0]  m_idx;
  reg  [1:0]  m_rx, m_tx;
  reg         m_glob, m_push;
  integer     error_cnt, n_checks, i;

  lmc_link_manager_regs u_lmc_link_manager_regs
  (
    .pclk(pclk), .presetn(presetn), .power_ok_n(power_ok_n),
    .warm_reset_n(warm_reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .manager_active(manager_active),
    .mode_send_enable(feat[0]), .disconnect_enable(feat[1]),
    .width_send_enable(feat[2]), .freq_send_enable(feat[3]),
    .idle_refresh_enable(feat[4]), .refresh_enable(feat[5]),
    .refresh_stop_interval(refresh_stop_interval),
    .refresh_stop_length(refresh_stop_length),
    .rx_idle_lane_state(rx_idle_lane_state),
    .tx_idle_lane_state(tx_idle_lane_state),
    .mc_active0(mc_active0), .mc_active1(mc_active1)
  );
////////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // xorshift source for data values
  function automatic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task chk(input string nm, input [31:0] e, input [31:0] g);
    n_checks = n_checks + 1;
    if (g !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task results;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task tick(input integer n);
    repeat (n) @(posedge pclk);
  endtask

  task chk_act;
    chk("mc_active0", m_act0, mc_active0);
    chk("mc_active1", m_act1, mc_active1);
  endtask

  // one apb transfer: writes update the model, reads compare masked data
  task acc(input w, input [7:0] a, input [31:0] d);
    integer     k;
    reg  [31:0] rd;
    reg         er;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k = k + 1;
    end
    while (pready !== 1'b1 && k < 16);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 16)
    begin
      error_cnt = error_cnt + 1;
      results;
    end
    {mask, exp} = {32'hFFFFFFFF, 32'h00000000};
    case (a)
      8'h24: if (w) m_st0 = d;
      8'h28: if (w) m_st1 = d;
      8'h2C: if (w) m_push = (d[21:20] == 2'b11);
      8'h30: exp = m_act0;
      8'h34: exp = m_act1;
      8'h50: if (w) m_glob = d[0]; else {mask, exp} = {32'h1, 31'h0, m_glob};
      8'hAC: if (w) {m_tx, m_rx} = d[26:23];
             else {mask, exp} = {32'h07800000, 5'h0, m_tx, m_rx, 23'h0};
      8'hF8: if (w) m_idx = d[19:16];
             else {mask, exp} = {32'h000F0000, 12'h0, m_idx, 16'h0};
      8'hFC: if (m_idx == 4'h0)
             begin
               if (w) m_cap = d[21:16];
               {mask, exp} = {32'h003F0000, 10'h0, m_cap, 16'h0};
             end
             else if (m_idx == 4'h2)
             begin
               if (w) {m_int, m_len} = d[11:0];
               {mask, exp} = {32'h00000FFF, 20'h0, m_int, m_len};
             end
      default: ;
    endcase
    if (m_push)
      {m_act0, m_act1} = {m_st0, m_st1};
    chk("pslverr", !(a inside {8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h50,
        8'h60, 8'hAC, 8'hF8, 8'hFC}), er);
    if (!w)
      chk("prdata", exp, rd & mask);
    @(posedge pclk);
  endtask
////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {seed, error_cnt, n_checks} = {32'h0000D023, 64'h0};
    {m_st0, m_st1, m_act0, m_act1, m_cap, m_int, m_len} = 0;
    {m_idx, m_rx, m_tx, m_glob, m_push} = 0;
    {presetn, power_ok_n, warm_reset_n, psel, penable, pwrite} = 6'h08;
    {paddr, pwdata} = 0;
    tick(6);
    presetn <= 1'b1;
    tick(5);
    power_ok_n <= 1'b1;
    tick(4);
    for (i = 0; i < 4; i = i + 1)
    begin
      acc(1, 8'hF8, i << 16);
      acc(1, 8'hFC, rnd());
      acc(0, 8'hFC, 0);
    end
    acc(1, 8'hF8, 32'h00020000);
    acc(1, 8'hFC, 32'h00000D63);
    tick(1);
    chk("interval", m_int, refresh_stop_interval);
    chk("length", m_len, refresh_stop_length);
    acc(1, 8'hF8, 0);
    acc(1, 8'hFC, 32'h003F0000);
    acc(1, 8'h50, 1);
    acc(0, 8'h50, 0);
    tick(8);
    chk("manager_active", 0, manager_active);
    chk("features", 0, feat);
    warm_reset_n <= 1'b0;
    tick(3);
    warm_reset_n <= 1'b1;
    for (i = 0; i < 16 && manager_active !== 1'b1; i = i + 1)
      @(posedge pclk);
    chk("manager_active", 1, manager_active);
    tick(2);
    chk("features", m_cap, feat);
    acc(1, 8'hAC, rnd());
    acc(0, 8'hAC, 0);
    chk("lane", {m_tx, m_rx},
        {tx_idle_lane_state, rx_idle_lane_state});
    acc(1, 8'hAC, rnd() | 32'h07800000);
    acc(0, 8'hAC, 0);
    chk("lane", 4'hF, {tx_idle_lane_state, rx_idle_lane_state});
    acc(0, 8'h40, 0);
    acc(1, 8'h40, rnd());
    acc(1, 8'h24, rnd());
    acc(1, 8'h28, rnd());
    acc(1, 8'h2C, 32'h00100000);
    acc(1, 8'h2C, 32'h00200000);
    tick(3);
    chk_act;
    acc(1, 8'h2C, 32'h00300000);
    tick(3);
    chk_act;
    acc(1, 8'h2C, 0);
    acc(1, 8'h24, rnd());
    tick(3);
    chk_act;
    acc(0, 8'h30, 0);
    // presetn reset keeps only width, freq and idle refresh bits
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    {m_st0, m_st1, m_act0, m_act1, m_int, m_len, m_idx} = 0;
    {m_rx, m_tx, m_glob, m_push, m_cap} = {7'h0, m_cap & 6'h1C};
    tick(2);
    acc(0, 8'hFC, 0);
    chk("features", 0, feat);
    acc(1, 8'hF8, 32'h00020000);
    acc(0, 8'hFC, 0);
    acc(1, 8'hFC, 32'h00000D63);
    power_ok_n <= 1'b0;
    tick(5);
    power_ok_n <= 1'b1;
    {m_cap, m_int, m_len} = 0;
    acc(0, 8'hFC, 0);
    acc(1, 8'hF8, 0);
    acc(0, 8'hFC, 0);
    results;
  end
endmodule
